// [verilog/clp_top.sv]
/*
 * Cold load pickup supervisor: detects a warm-to-cold load transition, raises a
 * temporary enable indication, supervises the following inrush and drops the
 * indication after settling or on the maximum-block timeout.
 * Assumes all flag inputs are synchronous to CLK_I, TICK_I is a one-cycle
 * timebase pulse and current comparisons are made outside.
 */
// Behaviour
// - Cold detection mode: breaker open, undercurrent, both, or either.
// - A detected warm-to-cold transition starts the load-off delay timer.
// - Load-off expiry with cold still present raises the enable output.
// - End of cold condition starts inrush supervision.
// - Current above inrush threshold marks an inrush as present.
// - Inrush is finished once current falls to 90% of threshold.
// - Finished inrush starts the settle timer.
// - On the inrush path enable drops after settle expiry, or earlier on max-block expiry.
// - Max-block timer runs from cold end; expiry drops enable regardless.
// - Max-block timer stops after current stays below 0.9 threshold for settle time.
// - Selected external or internal block input holds the function inactive.
// - A running auto-reclose sequence blocks the function when so configured.
// - Only an indication is produced, never a trip command.
`timescale 1ns/1ps
`include "clp_consts.svh"
module clp_top #(
   parameter int DATA_W = 16
) (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic CE_I,
   input wire logic TICK_I,
   input wire logic BREAKER_OPEN_I,
   input wire logic UNDERCURRENT_I,
   input wire logic ABOVE_INRUSH_I,
   input wire logic BELOW_INRUSH_90_I,
   input wire logic EXT_BLOCK_I,
   input wire logic INT_BLOCK_I,
   input wire logic AUTO_RECLOSE_RUNNING_I,
   input wire logic [`CLP_ADDR_W-1:0] ADDR_I,
   input wire logic [DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [DATA_W-1:0] RDATA_O,
   output logic COLD_LOAD_ENABLE_OUT_O,
   output logic UNDERCURRENT_FLAG_O,
   output logic IRQ_O
);
   import clp_pkg::*;

   logic [`CLP_CTRL_USED_W-1:0] ctrl_q;
   logic [DATA_W-1:0] loadoff_q;
   logic [DATA_W-1:0] settle_q;
   logic [DATA_W-1:0] maxblk_q;
   clp_state_t state_q;
   clp_state_t state_d;
   logic enable_q;
   logic inrush_q;
   logic [`CLP_NUM_EV-1:0] ev;
   logic [`CLP_NUM_EV-1:0] irq_stat;
   logic [`CLP_NUM_EV-1:0] irq_en;
   logic cold;
   logic blocked;
   clp_mode_t mode;
   logic lo_start, lo_stop, lo_done, lo_run;
   logic st_start, st_stop, st_done, st_run;
   logic mb_start, mb_stop, mb_done, mb_run;
   logic wr_ctrl, wr_loadoff, wr_settle, wr_maxblk, wr_irq_clr, wr_irq_en;

   assign mode = clp_mode_t'(ctrl_q[`CLP_CTRL_MODE_HI:`CLP_CTRL_MODE_LO]);

   // register write decode
   always_comb begin
      wr_ctrl = 1'b0;
      wr_loadoff = 1'b0;
      wr_settle = 1'b0;
      wr_maxblk = 1'b0;
      wr_irq_clr = 1'b0;
      wr_irq_en = 1'b0;
      if (WR_I) begin
         if (ADDR_I == `CLP_OFS_CTRL) begin
            wr_ctrl = 1'b1;
         end else if (ADDR_I == `CLP_OFS_LOADOFF) begin
            wr_loadoff = 1'b1;
         end else if (ADDR_I == `CLP_OFS_SETTLE) begin
            wr_settle = 1'b1;
         end else if (ADDR_I == `CLP_OFS_MAXBLK) begin
            wr_maxblk = 1'b1;
         end else if (ADDR_I == `CLP_OFS_IRQ_CLR) begin
            wr_irq_clr = 1'b1;
         end else if (ADDR_I == `CLP_OFS_IRQ_EN) begin
            wr_irq_en = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ctrl_q <= `CLP_CTRL_RST;
      end else if (CE_I && wr_ctrl) begin
         ctrl_q <= WDATA_I[`CLP_CTRL_USED_W-1:0];
      end
   end

   // durations reload on the next start only, a running timer keeps its count
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         loadoff_q <= DATA_W'(`CLP_LOADOFF_RST);
         settle_q <= DATA_W'(`CLP_SETTLE_RST);
         maxblk_q <= DATA_W'(`CLP_MAXBLK_RST);
      end else if (CE_I) begin
         if (wr_loadoff) begin
            loadoff_q <= WDATA_I;
         end
         if (wr_settle) begin
            settle_q <= WDATA_I;
         end
         if (wr_maxblk) begin
            maxblk_q <= WDATA_I;
         end
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RDATA_O <= '0;
      end else if (CE_I) begin
         RDATA_O <= '0;
         if (RD_I) begin
            if (ADDR_I == `CLP_OFS_CTRL) begin
               RDATA_O <= DATA_W'(ctrl_q);
            end else if (ADDR_I == `CLP_OFS_LOADOFF) begin
               RDATA_O <= loadoff_q;
            end else if (ADDR_I == `CLP_OFS_SETTLE) begin
               RDATA_O <= settle_q;
            end else if (ADDR_I == `CLP_OFS_MAXBLK) begin
               RDATA_O <= maxblk_q;
            end else if (ADDR_I == `CLP_OFS_STATUS) begin
               RDATA_O <= DATA_W'({state_q, inrush_q, UNDERCURRENT_FLAG_O, enable_q});
            end else if (ADDR_I == `CLP_OFS_IRQ_STAT) begin
               RDATA_O <= DATA_W'(irq_stat);
            end else if (ADDR_I == `CLP_OFS_IRQ_EN) begin
               RDATA_O <= DATA_W'(irq_en);
            end
         end
      end
   end

   // cold condition per selected mode
   always_comb begin
      case (mode)
         CLP_MODE_BKR: cold = BREAKER_OPEN_I;
         CLP_MODE_UC: cold = UNDERCURRENT_I;
         CLP_MODE_AND: cold = BREAKER_OPEN_I & UNDERCURRENT_I;
         default: cold = BREAKER_OPEN_I | UNDERCURRENT_I;
      endcase
   end

   // a disabled function counts as blocked
   assign blocked = !ctrl_q[`CLP_CTRL_FUNC_EN]
                  | (ctrl_q[`CLP_CTRL_EXT_SEL] & EXT_BLOCK_I)
                  | (ctrl_q[`CLP_CTRL_INT_SEL] & INT_BLOCK_I)
                  | (ctrl_q[`CLP_CTRL_AR_BLK] & AUTO_RECLOSE_RUNNING_I);

   always_comb begin
      state_d = state_q;
      lo_start = 1'b0;
      st_start = 1'b0;
      mb_start = 1'b0;
      if (blocked) begin
         state_d = CLP_IDLE;
      end else begin
         case (state_q)
            CLP_IDLE: begin
               if (cold) begin
                  state_d = CLP_LOADOFF;
                  lo_start = 1'b1;
               end
            end
            CLP_LOADOFF: begin
               if (!cold) begin
                  state_d = CLP_IDLE;
               end else if (lo_done) begin
                  state_d = CLP_COLD;
               end
            end
            CLP_COLD: begin
               if (!cold) begin
                  state_d = CLP_SUPERV;
                  mb_start = 1'b1;
               end
            end
            CLP_SUPERV: begin
               if (cold) begin
                  state_d = CLP_COLD;
               end else if (mb_done) begin
                  state_d = CLP_IDLE;
               end else if ((inrush_q || ABOVE_INRUSH_I) && BELOW_INRUSH_90_I) begin
                  state_d = CLP_SETTLE;
                  st_start = 1'b1;
               end
            end
            CLP_SETTLE: begin
               if (cold) begin
                  state_d = CLP_COLD;
               end else if (mb_done) begin
                  state_d = CLP_IDLE;
               end else if (!BELOW_INRUSH_90_I) begin
                  state_d = CLP_SUPERV;
               end else if (st_done) begin
                  state_d = CLP_IDLE;
               end
            end
            default: state_d = CLP_IDLE;
         endcase
      end
   end

   // each timer stops once the next state leaves its own stage; max-block runs through supervise and settle
   assign lo_stop = (state_d != CLP_LOADOFF);
   assign st_stop = (state_d != CLP_SETTLE);
   assign mb_stop = (state_d != CLP_SUPERV) && (state_d != CLP_SETTLE);

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_q <= CLP_IDLE;
      end else if (CE_I) begin
         state_q <= state_d;
      end
   end

   // indication only, no trip path exists in this block
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         enable_q <= 1'b0;
      end else if (CE_I) begin
         enable_q <= (state_d == CLP_COLD) || (state_d == CLP_SUPERV)
                   || (state_d == CLP_SETTLE);
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         inrush_q <= 1'b0;
      end else if (CE_I) begin
         if (state_d != CLP_SUPERV && state_d != CLP_SETTLE) begin
            inrush_q <= 1'b0;
         end else if (ABOVE_INRUSH_I) begin
            inrush_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         UNDERCURRENT_FLAG_O <= 1'b0;
      end else if (CE_I) begin
         UNDERCURRENT_FLAG_O <= UNDERCURRENT_I;
      end
   end

   assign COLD_LOAD_ENABLE_OUT_O = enable_q;

   always_comb begin
      ev = '0;
      ev[`CLP_EV_ON] = (state_q == CLP_LOADOFF) && (state_d == CLP_COLD);
      ev[`CLP_EV_OFF] = enable_q && (state_d == CLP_IDLE);
      ev[`CLP_EV_INRUSH] = (state_d == CLP_SUPERV) && ABOVE_INRUSH_I && !inrush_q;
      ev[`CLP_EV_MAXBLK] = mb_done && !blocked && !cold
                         && (state_q == CLP_SUPERV || state_q == CLP_SETTLE);
   end

   // all three delays share one tick so their ratios stay exact
   clp_timer #(.W(DATA_W)) u_loadoff (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .tick_i(TICK_I),
      .start_i(lo_start),
      .stop_i(lo_stop),
      .load_i(loadoff_q),
      .run_o(lo_run),
      .done_o(lo_done)
   );

   clp_timer #(.W(DATA_W)) u_settle (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .tick_i(TICK_I),
      .start_i(st_start),
      .stop_i(st_stop),
      .load_i(settle_q),
      .run_o(st_run),
      .done_o(st_done)
   );

   clp_timer #(.W(DATA_W)) u_maxblk (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .tick_i(TICK_I),
      .start_i(mb_start),
      .stop_i(mb_stop),
      .load_i(maxblk_q),
      .run_o(mb_run),
      .done_o(mb_done)
   );

   clp_irq #(.N(`CLP_NUM_EV)) u_irq (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .ev_i(ev),
      .clr_wr_i(wr_irq_clr),
      .en_wr_i(wr_irq_en),
      .wdata_i(WDATA_I[`CLP_NUM_EV-1:0]),
      .stat_o(irq_stat),
      .en_o(irq_en),
      .irq_o(IRQ_O)
   );

   a_mode_bkr_only: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CE_I && mode == CLP_MODE_BKR && !blocked && state_q == CLP_IDLE && !BREAKER_OPEN_I
      |=> state_q == CLP_IDLE)
      else $error("undercurrent alone started load-off in breaker mode");
   a_mode_and_both: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CE_I && mode == CLP_MODE_AND && !blocked && state_q == CLP_IDLE
      && (BREAKER_OPEN_I != UNDERCURRENT_I) |=> state_q == CLP_IDLE)
      else $error("and mode started on a single condition");
   a_loadoff_start: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CE_I && state_q == CLP_IDLE && !blocked && cold |=> state_q == CLP_LOADOFF && lo_run)
      else $error("cold transition did not start load-off timer");
   a_enable_rise: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      $rose(enable_q) |-> $past(state_q) == CLP_LOADOFF && $past(lo_done) && $past(cold))
      else $error("enable rose without load-off expiry");
   a_superv_entry: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CE_I && state_q == CLP_COLD && !blocked && !cold
      |=> state_q == CLP_SUPERV && mb_run && enable_q)
      else $error("cold end did not start supervision and max-block");
   a_inrush_mark: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CE_I && state_q == CLP_SUPERV && state_d == CLP_SUPERV && ABOVE_INRUSH_I |=> inrush_q)
      else $error("inrush above threshold not marked");
   a_settle_start: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CE_I && state_q == CLP_SUPERV && !blocked && !cold && !mb_done && inrush_q
      && BELOW_INRUSH_90_I |=> state_q == CLP_SETTLE && st_run)
      else $error("inrush end did not start settle timer");
   a_enable_fall: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      $fell(enable_q) |-> $past(blocked) || $past(st_done) || $past(mb_done))
      else $error("enable dropped without settle or max-block expiry");
   a_maxblk_stop: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CE_I && state_q == CLP_SETTLE && st_done && !blocked && !cold && !mb_done
      && BELOW_INRUSH_90_I |=> !mb_run ##1 !mb_done)
      else $error("max-block timer not stopped after settling");
   a_block_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CE_I && blocked ##1 CE_I && blocked |=> !enable_q && state_q == CLP_IDLE && !lo_run)
      else $error("function active while blocked");
   a_uc_flag: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CE_I |=> UNDERCURRENT_FLAG_O == $past(UNDERCURRENT_I))
      else $error("undercurrent status flag does not follow input");

endmodule

// [verilog/clp_consts.svh]
/*
 * Register offsets, field positions, reset values and event bit positions for the
 * cold load pickup block.
 * Included by bare name by every file that needs them; definitions only.
 */
`ifndef CLP_CONSTS_SVH
`define CLP_CONSTS_SVH

`define CLP_ADDR_W 5

`define CLP_OFS_CTRL 5'h00
`define CLP_OFS_LOADOFF 5'h04
`define CLP_OFS_SETTLE 5'h08
`define CLP_OFS_MAXBLK 5'h0C
`define CLP_OFS_STATUS 5'h10
`define CLP_OFS_IRQ_STAT 5'h14
`define CLP_OFS_IRQ_CLR 5'h18
`define CLP_OFS_IRQ_EN 5'h1C

`define CLP_CTRL_FUNC_EN 0
`define CLP_CTRL_MODE_LO 1
`define CLP_CTRL_MODE_HI 2
`define CLP_CTRL_EXT_SEL 3
`define CLP_CTRL_INT_SEL 4
`define CLP_CTRL_AR_BLK 5
`define CLP_CTRL_USED_W 6

`define CLP_CTRL_RST 6'h21
`define CLP_LOADOFF_RST 16'h0064
`define CLP_SETTLE_RST 16'h000A
`define CLP_MAXBLK_RST 16'h01F4

`define CLP_ST_ENABLE 0
`define CLP_ST_UNDERCUR 1
`define CLP_ST_INRUSH 2
`define CLP_ST_STATE_LO 3
`define CLP_ST_STATE_HI 5

`define CLP_EV_ON 0
`define CLP_EV_OFF 1
`define CLP_EV_INRUSH 2
`define CLP_EV_MAXBLK 3
`define CLP_NUM_EV 4

`endif

// [verilog/clp_pkg.sv]
/*
 * Types shared by the cold load pickup block: detection modes and sequencer states.
 * Assumes nothing of its surroundings.
 */
package clp_pkg;

   typedef enum logic [1:0] {
      CLP_MODE_BKR = 2'h0,
      CLP_MODE_UC = 2'h1,
      CLP_MODE_AND = 2'h2,
      CLP_MODE_OR = 2'h3
   } clp_mode_t;

   // gray along idle -> load-off -> cold -> supervise -> settle
   typedef enum logic [2:0] {
      CLP_IDLE = 3'h0,
      CLP_LOADOFF = 3'h1,
      CLP_COLD = 3'h3,
      CLP_SUPERV = 3'h2,
      CLP_SETTLE = 3'h6
   } clp_state_t;

endpackage

// [verilog/clp_timer.sv]
/*
 * Tick-driven down-counting delay timer with reload, stop and a one-cycle done pulse.
 * Assumes tick_i is a synchronous one-cycle pulse and ce_i freezes the counter.
 */
`timescale 1ns/1ps
module clp_timer #(
   parameter int W = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic tick_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic [W-1:0] load_i,
   output logic run_o,
   output logic done_o
);

   logic [W-1:0] cnt_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
         run_o <= 1'b0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (stop_i) begin
            run_o <= 1'b0;
         end else if (start_i) begin
            cnt_q <= load_i;
            run_o <= 1'b1;
         end else if (run_o && tick_i) begin
            // a zero load still takes one tick
            if (cnt_q <= W'(1)) begin
               run_o <= 1'b0;
               done_o <= 1'b1;
            end else begin
               cnt_q <= cnt_q - W'(1);
            end
         end
      end
   end

endmodule

// [verilog/clp_irq.sv]
/*
 * Sticky event status, enable mask and level interrupt for the cold load pickup block.
 * Assumes write strobes are one cycle and ce_i freezes all state.
 */
`timescale 1ns/1ps
module clp_irq #(
   parameter int N = 4
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [N-1:0] ev_i,
   input wire logic clr_wr_i,
   input wire logic en_wr_i,
   input wire logic [N-1:0] wdata_i,
   output logic [N-1:0] stat_o,
   output logic [N-1:0] en_o,
   output logic irq_o
);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stat_o <= '0;
      end else if (ce_i) begin
         // a new event beats a clear in the same cycle
         stat_o <= (stat_o & ~(clr_wr_i ? wdata_i : '0)) | ev_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_o <= '0;
      end else if (ce_i && en_wr_i) begin
         en_o <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= |((stat_o & ~(clr_wr_i ? wdata_i : '0) | ev_i) & (en_wr_i ? wdata_i : en_o));
      end
   end

endmodule

// [dv/clp_plant.sv]
/* Behavioural model of the breaker and its current measurement: flags and timebase tick.
   Assumes the bench sets breaker and current level by non-blocking assignment. */
`timescale 1ns/1ps
module clp_plant #(
   parameter int TICK_DIV = 4
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic brk_open_i,
   input wire logic [1:0] lvl_i,
   output logic tick_o,
   output logic breaker_open_o,
   output logic undercurrent_o,
   output logic above_inrush_o,
   output logic below_90_o
);
   // lvl_i: 0 no load, 1 normal, 2 above inrush, 3 between 90% and 100% of inrush
   logic [7:0] div_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_q <= 8'h00;
         tick_o <= 1'b0;
      end else begin
         div_q <= (div_q == 8'(TICK_DIV - 1)) ? 8'h00 : div_q + 8'h01;
         tick_o <= (div_q == 8'(TICK_DIV - 1));
      end
   end
   // one breaker; its own transformers give the current flags
   assign breaker_open_o = brk_open_i;
   assign undercurrent_o = (lvl_i == 2'h0);
   assign above_inrush_o = (lvl_i == 2'h2);
   assign below_90_o = (lvl_i == 2'h0) || (lvl_i == 2'h1);
endmodule

// [dv/test_clp_top.sv]
/* Self-checking bench of the cold load pickup block with the plant model.
   Assumes a 20 MHz clock and the register map of the block's header. */
`timescale 1ns/1ps
`include "clp_consts.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module test_clp_top;
   import clp_pkg::*;
   logic clk = 1'b0;
   logic ce = 1'b1;
   logic rst_n = 1'b0;
   logic brk = 1'b0;
   logic [1:0] lvl = 2'h1;
   logic ext_blk = 1'b0;
   logic int_blk = 1'b0;
   logic ar_run = 1'b0;
   logic [`CLP_ADDR_W-1:0] addr = '0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic en, ucf, irq, tick, bo, uc, ab, b90;
   int fails = 0;
   int total_checks = 0;
   always #25 clk = ~clk;
   clp_plant clp_plant_inst (.clk_i(clk), .rst_n_i(rst_n), .brk_open_i(brk), .lvl_i(lvl),
      .tick_o(tick), .breaker_open_o(bo), .undercurrent_o(uc), .above_inrush_o(ab),
      .below_90_o(b90));
   clp_top clp_top_inst (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .TICK_I(tick),
      .BREAKER_OPEN_I(bo), .UNDERCURRENT_I(uc), .ABOVE_INRUSH_I(ab),
      .BELOW_INRUSH_90_I(b90), .EXT_BLOCK_I(ext_blk), .INT_BLOCK_I(int_blk),
      .AUTO_RECLOSE_RUNNING_I(ar_run), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .COLD_LOAD_ENABLE_OUT_O(en), .UNDERCURRENT_FLAG_O(ucf),
      .IRQ_O(irq));
   task automatic wr_reg(input logic [`CLP_ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [`CLP_ADDR_W-1:0] a, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask
   // ticks counted are those the design samples while waiting
   task automatic wait_en(input logic v, input int lim, output int t);
      t = 0;
      for (int i = 0; i < lim; i++) begin
         @(posedge clk);
         #1;
         if (en === v) break;
         if (tick === 1'b1) t++;
      end
   endtask
   // disabling the function forces idle, so each case starts warm
   task automatic warm(input logic [15:0] c);
      brk <= 1'b0;
      lvl <= 2'h1;
      wr_reg(`CLP_OFS_CTRL, 16'h0000);
      wr_reg(`CLP_OFS_CTRL, c);
   endtask
   task automatic t_reset();
      rd_chk(`CLP_OFS_CTRL, 16'h0021);
      rd_chk(`CLP_OFS_LOADOFF, 16'h0064);
      rd_chk(`CLP_OFS_SETTLE, 16'h000A);
      rd_chk(`CLP_OFS_MAXBLK, 16'h01F4);
      rd_chk(`CLP_OFS_IRQ_EN, 16'h0000);
      rd_chk(`CLP_OFS_IRQ_STAT, 16'h0000);
      rd_chk(5'h02, 16'h0000);
      wr_reg(`CLP_OFS_STATUS, 16'hFFFF);
      rd_chk(`CLP_OFS_STATUS, 16'h0000);
      @(posedge clk);
      #1;
      `CHK(rdata, 16'h0000)
      wr_reg(`CLP_OFS_LOADOFF, 16'h0003);
      wr_reg(`CLP_OFS_SETTLE, 16'h0003);
      rd_chk(`CLP_OFS_LOADOFF, 16'h0003);
      // a write while the clock enable is low must not land
      ce <= 1'b0;
      wr_reg(`CLP_OFS_LOADOFF, 16'h0005);
      ce <= 1'b1;
      rd_chk(`CLP_OFS_LOADOFF, 16'h0003);
   endtask
   task automatic t_modes();
      logic [1:0] m;
      logic e;
      int t;
      for (int i = 0; i < 16; i++) begin
         m = 2'(i >> 2);
         warm({10'h000, 1'b1, 2'b00, m, 1'b1});
         // breaker contact and current flags run through all four combinations here
         brk <= i[1];
         lvl <= {1'b0, i[0]};
         case (m)
            CLP_MODE_BKR: e = i[1];
            CLP_MODE_UC: e = !i[0];
            CLP_MODE_AND: e = i[1] && !i[0];
            default: e = i[1] || !i[0];
         endcase
         wait_en(1'b1, 40, t);
         `CHK(en, e)
      end
   endtask
   task automatic t_inrush();
      int t;
      wr_reg(`CLP_OFS_MAXBLK, 16'h0040);
      wr_reg(`CLP_OFS_IRQ_CLR, 16'h000F);
      warm(16'h0021);
      brk <= 1'b1;
      lvl <= 2'h0;
      wait_en(1'b1, 60, t);
      `CHK(t >= 2 && t <= 4, 1'b1)
      `CHK(en, 1'b1)
      brk <= 1'b0;
      lvl <= 2'h2;
      wait_en(1'b0, 40, t);
      `CHK(en, 1'b1)
      rd_chk(`CLP_OFS_STATUS, 16'h0015);
      lvl <= 2'h3;
      wait_en(1'b0, 40, t);
      `CHK(en, 1'b1)
      lvl <= 2'h1;
      wait_en(1'b0, 60, t);
      `CHK(t >= 2 && t <= 4, 1'b1)
      `CHK(en, 1'b0)
      // long enough for the max-block count to have run out if it was not stopped
      repeat (300) @(posedge clk);
      rd_chk(`CLP_OFS_IRQ_STAT, 16'h0007);
   endtask
   task automatic t_maxblk();
      int t;
      wr_reg(`CLP_OFS_MAXBLK, 16'h0004);
      wr_reg(`CLP_OFS_IRQ_EN, 16'h0008);
      wr_reg(`CLP_OFS_IRQ_CLR, 16'h000F);
      rd_chk(`CLP_OFS_IRQ_EN, 16'h0008);
      warm(16'h0021);
      brk <= 1'b1;
      lvl <= 2'h0;
      wait_en(1'b1, 60, t);
      `CHK(irq, 1'b0)
      brk <= 1'b0;
      lvl <= 2'h2;
      wait_en(1'b0, 60, t);
      `CHK(t >= 3 && t <= 5, 1'b1)
      `CHK(en, 1'b0)
      @(posedge clk);
      #1;
      `CHK(irq, 1'b1)
      wr_reg(`CLP_OFS_IRQ_CLR, 16'h0008);
      @(posedge clk);
      #1;
      `CHK(irq, 1'b0)
      rd_chk(`CLP_OFS_IRQ_STAT, 16'h0007);
      wr_reg(`CLP_OFS_IRQ_EN, 16'h0000);
      lvl <= 2'h1;
   endtask
   task automatic t_block();
      int t;
      warm(16'h0029);
      brk <= 1'b1;
      lvl <= 2'h0;
      wait_en(1'b1, 60, t);
      int_blk <= 1'b1;
      wait_en(1'b0, 8, t);
      `CHK(en, 1'b1)
      ext_blk <= 1'b1;
      wait_en(1'b0, 3, t);
      `CHK(en, 1'b0)
      ext_blk <= 1'b0;
      int_blk <= 1'b0;
      wait_en(1'b1, 60, t);
      `CHK(en, 1'b1)
      ar_run <= 1'b1;
      wait_en(1'b0, 3, t);
      `CHK(en, 1'b0)
      ar_run <= 1'b0;
      wait_en(1'b1, 60, t);
      wr_reg(`CLP_OFS_CTRL, 16'h0009);
      ar_run <= 1'b1;
      wait_en(1'b0, 8, t);
      `CHK(en, 1'b1)
      ar_run <= 1'b0;
      wr_reg(`CLP_OFS_CTRL, 16'h0011);
      int_blk <= 1'b1;
      wait_en(1'b0, 3, t);
      `CHK(en, 1'b0)
      int_blk <= 1'b0;
   endtask
   task automatic t_ucflag();
      warm(16'h0021);
      @(posedge clk);
      lvl <= 2'h0;
      #1;
      `CHK(ucf, 1'b0)
      @(posedge clk);
      #1;
      `CHK(ucf, 1'b1)
      rd_chk(`CLP_OFS_STATUS, 16'h0002);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_modes();
      t_inrush();
      t_maxblk();
      t_block();
      t_ucflag();
      results();
   end
   // the sequence needs some 1200 cycles; this leaves a wide margin
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      results();
   end
endmodule
